// file: core/rcr_core.sv
// rcr_core: sequences unconditional, conditional and interrupt exits, restoring
// program counter, loop context and, for interrupt exits, debug and status words.
// assumes two stack read ports that hold rdata valid while ack is high, and a wishbone master.
`timescale 1ns/1ps

module rcr_core (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// exit commands from decode
	input rcr_pkg::rcr_cmd_t cmd_in,
	output logic cmd_ready_out,
	output logic reject_out,
	output logic done_out,
	output logic taken_out,
	output logic busy_out,
	// condition flags
	input rcr_pkg::rcr_flags_t flags_in,
	// system stack read port
	output rcr_pkg::rcr_mem_req_t sys_req_out,
	input wire logic [15:0] sys_rdata_in,
	input wire logic sys_ack_in,
	// data stack read port
	output rcr_pkg::rcr_mem_req_t dat_req_out,
	input wire logic [15:0] dat_rdata_in,
	input wire logic dat_ack_in,
	// restored context
	output logic [23:0] program_counter_out,
	output logic [7:0] loop_ctx_out,
	output logic [15:0] status_word_one_out,
	output logic [15:0] status_word_two_out,
	output logic [6:0] status_word_zero_hi_out,
	output logic [15:0] debug_state_out,
	// wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out
);

	typedef enum logic [2:0] {
		RCR_IDLE,
		RCR_ADDR,
		RCR_ACCESS,
		RCR_READ,
		RCR_EXEC
	} rcr_state_t;

	rcr_state_t state_q;
	rcr_pkg::rcr_kind_t kind_q;
	logic [3:0] cond_q;
	logic mode_fast_q, fast_mode_q;
	rcr_pkg::rcr_flags_t flags_q;
	logic cond_ok, cond_ok_q;
	logic need_s, need_d, got_s_q, got_d_q, pop_s, pop_d, step;
	logic [15:0] hi_q, lo_q, ssp_q, sp_q, st1_q, st2_q, dbg_q;
	logic [31:0] pair_q, rdat_q, rdat_d;
	logic [23:0] pc_q;
	logic [7:0] lctx_q, wb_ofs;
	logic [6:0] st0_hi_q;
	logic done_q, taken_q, reject_q, ack_q;
	logic wb_req, wb_wr;
	logic wide_cmp, acc_zero, acc_neg;

	// byte-lane merge for register writes
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wdat[i*8 +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	// handshake outputs
	assign cmd_ready_out = (state_q == RCR_IDLE);
	assign busy_out = (state_q != RCR_IDLE);
	assign done_out = done_q;
	assign taken_out = taken_q;
	assign reject_out = reject_q;
	assign wb_ack_out = ack_q;
	assign wb_dat_out = rdat_q;

	// restored context outputs all come from flip-flops
	assign program_counter_out = pc_q;
	assign loop_ctx_out = lctx_q;
	assign status_word_one_out = st1_q;
	assign status_word_two_out = st2_q;
	assign status_word_zero_hi_out = st0_hi_q;
	assign debug_state_out = dbg_q;

	// flags are registered once, so a flag written this cycle is seen by the test next cycle
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_in;
		end
	end

	// accumulator tests; legacy mode widens the compare to all guard bits
	assign wide_cmp = st1_q[rcr_pkg::ST1_WIDE_BIT] | st1_q[rcr_pkg::ST1_LEGACY_BIT];
	assign acc_zero = wide_cmp ? (flags_q.acc == '0) : (flags_q.acc[rcr_pkg::NARROW_SIGN_BIT:0] == '0);
	assign acc_neg = wide_cmp ? flags_q.acc[rcr_pkg::WIDE_SIGN_BIT] : flags_q.acc[rcr_pkg::NARROW_SIGN_BIT];

	// single condition selected by the command's field
	always_comb begin
		case (cond_q)
			rcr_pkg::COND_ALWAYS: cond_ok = 1'b1;
			rcr_pkg::COND_ACC_EQ0: cond_ok = acc_zero;
			rcr_pkg::COND_ACC_NE0: cond_ok = !acc_zero;
			rcr_pkg::COND_ACC_LT0: cond_ok = acc_neg;
			rcr_pkg::COND_ACC_GE0: cond_ok = !acc_neg;
			rcr_pkg::COND_OVF_SET: cond_ok = flags_q.ovf;
			rcr_pkg::COND_OVF_CLR: cond_ok = !flags_q.ovf;
			rcr_pkg::COND_CARRY_SET: cond_ok = flags_q.carry;
			rcr_pkg::COND_CARRY_CLR: cond_ok = !flags_q.carry;
			rcr_pkg::COND_TC1_SET: cond_ok = flags_q.tc1;
			rcr_pkg::COND_TC1_CLR: cond_ok = !flags_q.tc1;
			rcr_pkg::COND_TC2_SET: cond_ok = flags_q.tc2;
			rcr_pkg::COND_TC2_CLR: cond_ok = !flags_q.tc2;
			default: cond_ok = 1'b0;
		endcase
	end

	// which stack ports pop in the current phase
	always_comb begin
		need_s = 1'b0;
		need_d = 1'b0;
		case (state_q)
			RCR_ADDR: begin
				// slow unconditional and interrupt exits pop the return context here
				need_s = (kind_q != rcr_pkg::RCR_KIND_CONDITIONAL_SUBROUTINE_EXIT) && !mode_fast_q;
				need_d = (kind_q != rcr_pkg::RCR_KIND_CONDITIONAL_SUBROUTINE_EXIT) && !mode_fast_q;
			end
			RCR_ACCESS: begin
				// debug word and status one pop even in fast mode
				need_s = (kind_q == rcr_pkg::RCR_KIND_INTERRUPT_EXIT);
				need_d = (kind_q == rcr_pkg::RCR_KIND_INTERRUPT_EXIT);
			end
			RCR_READ: begin
				need_s = (kind_q == rcr_pkg::RCR_KIND_INTERRUPT_EXIT) ||
					((kind_q == rcr_pkg::RCR_KIND_CONDITIONAL_SUBROUTINE_EXIT) && cond_ok && !mode_fast_q);
				need_d = (kind_q == rcr_pkg::RCR_KIND_INTERRUPT_EXIT) ||
					((kind_q == rcr_pkg::RCR_KIND_CONDITIONAL_SUBROUTINE_EXIT) && cond_ok && !mode_fast_q);
			end
			default: need_s = 1'b0;
		endcase
	end

	// a port that already answered in this phase is not asked again
	assign sys_req_out.rd = need_s && !got_s_q;
	assign sys_req_out.addr = ssp_q;
	assign dat_req_out.rd = need_d && !got_d_q;
	assign dat_req_out.addr = sp_q;
	assign pop_s = sys_req_out.rd && sys_ack_in;
	assign pop_d = dat_req_out.rd && dat_ack_in;

	// a phase ends when both ports are served; slow memory stretches it
	assign step = (!need_s || got_s_q || sys_ack_in) && (!need_d || got_d_q || dat_ack_in);

	// phase sequencer: decode, address, access, read, execute
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q <= RCR_IDLE;
			kind_q <= rcr_pkg::RCR_KIND_NONE;
			cond_q <= rcr_pkg::COND_ALWAYS;
			mode_fast_q <= 1'b0;
			cond_ok_q <= 1'b0;
		end else begin
			case (state_q)
				RCR_IDLE: begin
					// repeated or empty commands are never started
					if (cmd_in.valid && !cmd_in.repeated && cmd_in.kind != rcr_pkg::RCR_KIND_NONE) begin
						state_q <= RCR_ADDR;
						kind_q <= cmd_in.kind;
						cond_q <= cmd_in.cond;
						mode_fast_q <= fast_mode_q; // mode held for the whole exit
					end
				end
				RCR_ADDR: begin
					if (step) begin
						state_q <= RCR_ACCESS;
					end
				end
				RCR_ACCESS: begin
					if (step) begin
						state_q <= RCR_READ;
					end
				end
				RCR_READ: begin
					if (step) begin
						state_q <= RCR_EXEC;
						cond_ok_q <= (kind_q != rcr_pkg::RCR_KIND_CONDITIONAL_SUBROUTINE_EXIT) || cond_ok;
					end
				end
				RCR_EXEC: begin
					state_q <= RCR_IDLE;
				end
				default: begin
					state_q <= RCR_IDLE;
				end
			endcase
		end
	end

	// per-phase answered marks, cleared when the phase moves on
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			got_s_q <= 1'b0;
			got_d_q <= 1'b0;
		end else if (step) begin
			got_s_q <= 1'b0;
			got_d_q <= 1'b0;
		end else begin
			got_s_q <= got_s_q | pop_s;
			got_d_q <= got_d_q | pop_d;
		end
	end

	// return context words: address phase pops, or the read phase pops of a conditional exit
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			hi_q <= '0;
			lo_q <= '0;
		end else begin
			if (pop_s && (state_q == RCR_ADDR || kind_q == rcr_pkg::RCR_KIND_CONDITIONAL_SUBROUTINE_EXIT)) begin
				hi_q <= sys_rdata_in;
			end
			if (pop_d && (state_q == RCR_ADDR || kind_q == rcr_pkg::RCR_KIND_CONDITIONAL_SUBROUTINE_EXIT)) begin
				lo_q <= dat_rdata_in;
			end
		end
	end

	// stack pointers: each pop steps its pointer by one word in the phase it happens;
	// the sequencer wins over a software write in the same cycle
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ssp_q <= rcr_pkg::SP_RST;
			sp_q <= rcr_pkg::SP_RST;
		end else begin
			if (pop_s) begin
				ssp_q <= ssp_q + 16'h0001;
			end else if (wb_wr && wb_ofs == rcr_pkg::OFS_SSP) begin
				ssp_q <= 16'(lane_merge({16'h0000, ssp_q}, wb_dat_in, wb_sel_in));
			end
			if (pop_d) begin
				sp_q <= sp_q + 16'h0001;
			end else if (wb_wr && wb_ofs == rcr_pkg::OFS_SP) begin
				sp_q <= 16'(lane_merge({16'h0000, sp_q}, wb_dat_in, wb_sel_in));
			end
		end
	end

	// program counter and loop context, loaded only by a taken exit
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pc_q <= '0;
			lctx_q <= '0;
		end else if (state_q == RCR_EXEC && cond_ok_q) begin
			if (mode_fast_q) begin
				pc_q <= pair_q[rcr_pkg::ADDR_W-1:0];
				lctx_q <= pair_q[31:rcr_pkg::ADDR_W];
			end else begin
				pc_q <= {hi_q[7:0], lo_q};
				lctx_q <= hi_q[15:8];
			end
		end
	end

	// processor registers restored by the interrupt exit, otherwise software-written
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			dbg_q <= rcr_pkg::DBG_RST;
			st1_q <= rcr_pkg::ST1_RST;
			st0_hi_q <= '0;
			st2_q <= rcr_pkg::ST2_RST;
		end else begin
			if (pop_s && state_q == RCR_ACCESS) begin
				dbg_q <= sys_rdata_in;
			end else if (wb_wr && wb_ofs == rcr_pkg::OFS_DBG) begin
				dbg_q <= 16'(lane_merge({16'h0000, dbg_q}, wb_dat_in, wb_sel_in));
			end
			if (pop_d && state_q == RCR_ACCESS) begin
				st1_q <= dat_rdata_in;
			end else if (wb_wr && wb_ofs == rcr_pkg::OFS_ST1) begin
				st1_q <= 16'(lane_merge({16'h0000, st1_q}, wb_dat_in, wb_sel_in));
			end
			if (pop_s && state_q == RCR_READ && kind_q == rcr_pkg::RCR_KIND_INTERRUPT_EXIT) begin
				st0_hi_q <= sys_rdata_in[15:rcr_pkg::ST0_HI_LSB];
			end else if (wb_wr && wb_ofs == rcr_pkg::OFS_ST0_HI && wb_sel_in[1]) begin
				st0_hi_q <= wb_dat_in[15:rcr_pkg::ST0_HI_LSB];
			end
			if (pop_d && state_q == RCR_READ && kind_q == rcr_pkg::RCR_KIND_INTERRUPT_EXIT) begin
				st2_q <= dat_rdata_in;
			end else if (wb_wr && wb_ofs == rcr_pkg::OFS_ST2) begin
				st2_q <= 16'(lane_merge({16'h0000, st2_q}, wb_dat_in, wb_sel_in));
			end
		end
	end

	// completion and refusal pulses
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			done_q <= 1'b0;
			taken_q <= 1'b0;
			reject_q <= 1'b0;
		end else begin
			done_q <= (state_q == RCR_EXEC);
			if (state_q == RCR_EXEC) begin
				taken_q <= cond_ok_q;
			end
			reject_q <= (state_q == RCR_IDLE) && cmd_in.valid && cmd_in.repeated;
		end
	end

	// wishbone decode; ack comes one cycle after the strobe and drops the next cycle
	assign wb_req = wb_cyc_in && wb_stb_in && !ack_q;
	assign wb_wr = wb_req && wb_we_in;
	assign wb_ofs = {wb_adr_in[7:2], 2'b00};

	// control and the fast pair; the pair only takes a full-word write so both halves move together
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			fast_mode_q <= 1'b0;
			pair_q <= rcr_pkg::PAIR_RST;
		end else if (wb_wr) begin
			if (wb_ofs == rcr_pkg::OFS_CTRL && wb_sel_in[0]) begin
				fast_mode_q <= wb_dat_in[rcr_pkg::CTRL_FAST_BIT];
			end
			if (wb_ofs == rcr_pkg::OFS_FAST_PAIR && wb_sel_in == 4'hf) begin
				pair_q <= wb_dat_in;
			end
		end
	end

	// read mux; unmapped offsets read zero and still acknowledge
	always_comb begin
		rdat_d = 32'h0000_0000;
		case (wb_ofs)
			rcr_pkg::OFS_CTRL: rdat_d[rcr_pkg::CTRL_FAST_BIT] = fast_mode_q;
			rcr_pkg::OFS_STATE: rdat_d = {28'h0000000, taken_q, busy_out, mode_fast_q, cond_ok_q};
			rcr_pkg::OFS_FAST_PAIR: rdat_d = pair_q;
			rcr_pkg::OFS_SSP: rdat_d = {16'h0000, ssp_q};
			rcr_pkg::OFS_SP: rdat_d = {16'h0000, sp_q};
			rcr_pkg::OFS_PC: rdat_d = {lctx_q, pc_q};
			rcr_pkg::OFS_ST0_HI: rdat_d = {16'h0000, st0_hi_q, 9'h000};
			rcr_pkg::OFS_ST1: rdat_d = {16'h0000, st1_q};
			rcr_pkg::OFS_ST2: rdat_d = {16'h0000, st2_q};
			rcr_pkg::OFS_DBG: rdat_d = {16'h0000, dbg_q};
			default: rdat_d = 32'h0000_0000;
		endcase
	end

	// registered answer
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ack_q <= 1'b0;
			rdat_q <= '0;
		end else begin
			ack_q <= wb_req;
			if (wb_req && !wb_we_in) begin
				rdat_q <= rdat_d;
			end
		end
	end

endmodule : rcr_core

// file: pkg/rcr_pkg.sv
// rcr_pkg: shared constants and carrier types of the return context restore block.
// assumes a 100 MHz core clock, 16-bit data memory stacks and a classic wishbone register bus.
package rcr_pkg;

	// widths
	localparam int ADDR_W = 24;
	localparam int LCTX_W = 8;
	localparam int WORD_W = 16;
	localparam int ACC_W = 40;

	// exit kinds carried by an issued command
	typedef enum logic [1:0] {
		RCR_KIND_NONE = 2'h0,
		RCR_KIND_RET = 2'h1,
		RCR_KIND_CONDITIONAL_SUBROUTINE_EXIT = 2'h2,
		RCR_KIND_INTERRUPT_EXIT = 2'h3
	} rcr_kind_t;

	// condition codes of the conditional exit
	localparam logic [3:0] COND_ALWAYS = 4'h0;
	localparam logic [3:0] COND_ACC_EQ0 = 4'h1;
	localparam logic [3:0] COND_ACC_NE0 = 4'h2;
	localparam logic [3:0] COND_ACC_LT0 = 4'h3;
	localparam logic [3:0] COND_ACC_GE0 = 4'h4;
	localparam logic [3:0] COND_OVF_SET = 4'h5;
	localparam logic [3:0] COND_OVF_CLR = 4'h6;
	localparam logic [3:0] COND_CARRY_SET = 4'h7;
	localparam logic [3:0] COND_CARRY_CLR = 4'h8;
	localparam logic [3:0] COND_TC1_SET = 4'h9;
	localparam logic [3:0] COND_TC1_CLR = 4'ha;
	localparam logic [3:0] COND_TC2_SET = 4'hb;
	localparam logic [3:0] COND_TC2_CLR = 4'hc;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATE = 8'h04;
	localparam logic [7:0] OFS_FAST_PAIR = 8'h08;
	localparam logic [7:0] OFS_SSP = 8'h0c;
	localparam logic [7:0] OFS_SP = 8'h10;
	localparam logic [7:0] OFS_PC = 8'h14;
	localparam logic [7:0] OFS_ST0_HI = 8'h18;
	localparam logic [7:0] OFS_ST1 = 8'h1c;
	localparam logic [7:0] OFS_ST2 = 8'h20;
	localparam logic [7:0] OFS_DBG = 8'h24;

	// field positions
	localparam int CTRL_FAST_BIT = 0;
	localparam int ST1_WIDE_BIT = 10;
	localparam int ST1_LEGACY_BIT = 5;
	localparam int ST0_HI_W = 7;
	localparam int ST0_HI_LSB = 9;
	localparam int WIDE_SIGN_BIT = 39;
	localparam int NARROW_SIGN_BIT = 31;

	// reset values
	localparam logic [15:0] ST1_RST = 16'h0000;
	localparam logic [15:0] ST2_RST = 16'h0000;
	localparam logic [15:0] DBG_RST = 16'h0000;
	localparam logic [15:0] SP_RST = 16'h0000;
	localparam logic [31:0] PAIR_RST = 32'h0000_0000;

	// issued exit command
	typedef struct packed {
		logic valid;
		rcr_kind_t kind;
		logic [3:0] cond;
		logic repeated;
	} rcr_cmd_t;

	// condition flags from the datapath
	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic ovf;
		logic carry;
		logic tc1;
		logic tc2;
	} rcr_flags_t;

	// one stack read port request
	typedef struct packed {
		logic rd;
		logic [WORD_W-1:0] addr;
	} rcr_mem_req_t;

endpackage : rcr_pkg

// file: test/rcr_core_chk.sv
// rcr_core_chk: concurrent checks on the exit sequencer and register bus ports.
// assumes one clock domain and a synchronous active low reset.
`timescale 1ns/1ps
module rcr_core_chk (
	// clock, reset and command side
	input wire logic clk_in,
	input wire logic rst_n_in,
	input rcr_pkg::rcr_cmd_t cmd_in,
	input wire logic cmd_ready_out,
	input wire logic reject_out,
	input wire logic done_out,
	input wire logic taken_out,
	input wire logic busy_out,
	// stack ports
	input rcr_pkg::rcr_mem_req_t sys_req_out,
	input wire logic sys_ack_in,
	input rcr_pkg::rcr_mem_req_t dat_req_out,
	input wire logic dat_ack_in,
	// context and bus
	input wire logic [23:0] program_counter_out,
	input wire logic [7:0] loop_ctx_out,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_ack_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic hit, go, rep;
	// command seen while idle, then split into accepted and refused
	assign hit = cmd_ready_out && cmd_in.valid && cmd_in.kind != rcr_pkg::RCR_KIND_NONE;
	assign go = hit && !cmd_in.repeated;
	assign rep = hit && cmd_in.repeated;
	AST_RET_MIN: assert property (go && cmd_in.kind == rcr_pkg::RCR_KIND_RET |=>
		(busy_out && !done_out) [*4]) else $error("exit ended early");
	AST_RET_MAX: assert property (go |-> ##[5:40] done_out) else $error("exit never ended");
	AST_REJECT: assert property (rep |=> reject_out && !busy_out) else $error("repeat not refused");
	AST_SYS_HOLD: assert property (sys_req_out.rd && !sys_ack_in |=>
		sys_req_out.rd && $stable(sys_req_out.addr)) else $error("pop dropped");
	AST_SYS_STEP: assert property (sys_req_out.rd && sys_ack_in |=>
		sys_req_out.addr == $past(sys_req_out.addr) + 16'h1) else $error("system pointer step");
	AST_DAT_STEP: assert property (dat_req_out.rd && dat_ack_in |=>
		dat_req_out.addr == $past(dat_req_out.addr) + 16'h1) else $error("data pointer step");
	AST_FALSE_KEEP: assert property (done_out && !taken_out |->
		$stable(program_counter_out) && $stable(loop_ctx_out)) else $error("false exit moved pc");
	AST_WB_ACK: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("bus ack late");
	// main scenarios reached
	cover property (go && cmd_in.kind == rcr_pkg::RCR_KIND_INTERRUPT_EXIT);
	cover property (done_out && !taken_out);
	cover property (rep);
endmodule : rcr_core_chk
bind rcr_core rcr_core_chk u_chk (.clk_in, .rst_n_in, .cmd_in, .cmd_ready_out, .reject_out, .done_out,
	.taken_out, .busy_out, .sys_req_out, .sys_ack_in, .dat_req_out, .dat_ack_in, .program_counter_out,
	.loop_ctx_out, .wb_cyc_in, .wb_stb_in, .wb_ack_out);

// file: test/rcr_core_tb.sv
// rcr_core_tb: directed scenarios for the exit sequencer, fast pair and register bus.
// assumes stack words {addr^ff, addr} on the system port and {addr^3c, addr} on the data port.
`timescale 1ns/1ps
module rcr_core_tb;
	logic clk_in, rst_n_in, cmd_ready_out, reject_out, done_out, taken_out, busy_out;
	logic sys_ack_in, dat_ack_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
	logic [1:0] wt;
	logic [3:0] wb_sel_in;
	logic [6:0] status_word_zero_hi_out;
	logic [7:0] wb_adr_in, loop_ctx_out;
	logic [15:0] sys_rdata_in, dat_rdata_in, status_word_one_out, status_word_two_out, debug_state_out;
	logic [23:0] program_counter_out;
	logic [31:0] wb_dat_in, wb_dat_out;
	rcr_pkg::rcr_cmd_t cmd_in;
	rcr_pkg::rcr_flags_t flags_in;
	rcr_pkg::rcr_mem_req_t sys_req_out, dat_req_out;
	int bad_count, compares;
	localparam logic [13:0] MASK = 14'h1333;
	// block under test and its two stack ports
	rcr_core uut (.clk_in, .rst_n_in, .cmd_in, .cmd_ready_out, .reject_out, .done_out, .taken_out, .busy_out,
		.flags_in, .sys_req_out, .sys_rdata_in, .sys_ack_in, .dat_req_out, .dat_rdata_in, .dat_ack_in,
		.program_counter_out, .loop_ctx_out, .status_word_one_out, .status_word_two_out,
		.status_word_zero_hi_out, .debug_state_out, .wb_cyc_in, .wb_stb_in, .wb_we_in,
		.wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out);
	rcr_mem_model #(.KEY(8'hff)) u_sys (.clk_in, .req_in(sys_req_out), .wait_in(wt),
		.rdata_out(sys_rdata_in), .ack_out(sys_ack_in));
	rcr_mem_model #(.KEY(8'h3c)) u_dat (.clk_in, .req_in(dat_req_out), .wait_in(wt),
		.rdata_out(dat_rdata_in), .ack_out(dat_ack_in));
	// free running core clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// verdict and end of run
	task automatic test_done();
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic hang();
		bad_count++;
		test_done();
	endtask : hang
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one classic cycle: hold until ack is sampled, then release
	task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= a;
		wb_sel_in <= s;
		wb_dat_in <= d;
		// look just after each edge, so the edge that follows is the one that samples ack
		do begin
			@(posedge clk_in);
			#1;
			n++;
		end while (wb_ack_out !== 1'b1 && n < 20);
		if (wb_ack_out !== 1'b1)
			hang();
		@(posedge clk_in);
		q = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, 4'hf, d, q);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 4'hf, 32'h0, q);
		chk(q, e);
	endtask : rdchk
	task automatic ptrs(input logic [15:0] s, input logic [15:0] p);
		wr(rcr_pkg::OFS_SSP, {16'h0, s});
		wr(rcr_pkg::OFS_SP, {16'h0, p});
	endtask : ptrs
	// issue one exit and count cycles up to its done pulse
	task automatic run(input rcr_pkg::rcr_kind_t k, input logic [3:0] c, output int lat);
		@(posedge clk_in);
		cmd_in <= '{1'b1, k, c, 1'b0};
		@(posedge clk_in);
		cmd_in <= '0;
		lat = 1; // the decode cycle in which the command was presented counts as the first
		do begin
			@(posedge clk_in);
			#1;
			lat++;
		end while (done_out !== 1'b1 && lat < 40);
		if (done_out !== 1'b1)
			hang();
	endtask : run
	task automatic t_regs();
		logic [31:0] q;
		rdchk(rcr_pkg::OFS_FAST_PAIR, rcr_pkg::PAIR_RST);
		rdchk(rcr_pkg::OFS_ST2, {16'h0, rcr_pkg::ST2_RST});
		wr(rcr_pkg::OFS_FAST_PAIR, 32'ha512_3456);
		wb(1'b1, rcr_pkg::OFS_FAST_PAIR, 4'h3, 32'h0, q);
		rdchk(rcr_pkg::OFS_FAST_PAIR, 32'ha512_3456);
		wr(8'h3c, 32'hffff_ffff);
		rdchk(8'h3c, 32'h0);
	endtask : t_regs
	task automatic t_ret_slow(input logic [1:0] w);
		int lat;
		ptrs(16'h0040, 16'h0080);
		wt <= w;
		run(rcr_pkg::RCR_KIND_RET, 4'h0, lat);
		if (w == 2'h0)
			chk(lat, 5);
		chk(taken_out, 1'b1);
		chk(program_counter_out, 24'h40bc80);
		chk(loop_ctx_out, 8'hbf);
		rdchk(rcr_pkg::OFS_PC, 32'hbf40_bc80);
		rdchk(rcr_pkg::OFS_STATE, 32'h0000_0009);
		rdchk(rcr_pkg::OFS_SSP, 32'h41);
		rdchk(rcr_pkg::OFS_SP, 32'h81);
		wt <= 2'h0;
	endtask : t_ret_slow
	task automatic t_fast();
		int lat;
		wr(rcr_pkg::OFS_CTRL, 32'h1);
		wr(rcr_pkg::OFS_FAST_PAIR, 32'h7e12_3456);
		ptrs(16'h0040, 16'h0080);
		run(rcr_pkg::RCR_KIND_RET, 4'h0, lat);
		chk(lat, 5);
		chk(program_counter_out, 24'h123456);
		chk(loop_ctx_out, 8'h7e);
		rdchk(rcr_pkg::OFS_SSP, 32'h40);
		run(rcr_pkg::RCR_KIND_INTERRUPT_EXIT, 4'h0, lat);
		chk(program_counter_out, 24'h123456);
		chk(debug_state_out, 16'hbf40);
		chk(status_word_one_out, 16'hbc80);
		chk(status_word_zero_hi_out, 7'h5f);
		chk(status_word_two_out, 16'hbd81);
		rdchk(rcr_pkg::OFS_SSP, 32'h42);
		rdchk(rcr_pkg::OFS_SP, 32'h82);
		wr(rcr_pkg::OFS_CTRL, 32'h0);
	endtask : t_fast
	task automatic t_interrupt_exit_slow();
		int lat;
		ptrs(16'h0010, 16'h0020);
		run(rcr_pkg::RCR_KIND_INTERRUPT_EXIT, 4'h0, lat);
		chk(program_counter_out, 24'h101c20);
		chk(loop_ctx_out, 8'hef);
		chk(debug_state_out, 16'hee11);
		chk(status_word_one_out, 16'h1d21);
		chk(status_word_zero_hi_out, 7'h76);
		chk(status_word_two_out, 16'h1e22);
		rdchk(rcr_pkg::OFS_SSP, 32'h13);
		rdchk(rcr_pkg::OFS_SP, 32'h23);
	endtask : t_interrupt_exit_slow
	// every condition code, pointers move only on a taken exit
	task automatic t_conditional_subroutine_exit();
		int lat;
		logic [15:0] s, p;
		logic [23:0] pce;
		wr(rcr_pkg::OFS_ST1, 32'h0);
		flags_in <= '{40'h0, 1'b1, 1'b0, 1'b1, 1'b0};
		ptrs(16'h0030, 16'h0060);
		s = 16'h0030;
		p = 16'h0060;
		for (int c = 0; c < 14; c++) begin
			run(rcr_pkg::RCR_KIND_CONDITIONAL_SUBROUTINE_EXIT, 4'(c), lat);
			chk(lat, 5);
			chk(taken_out, MASK[c]);
			if (MASK[c]) begin
				pce = {s[7:0], p[7:0] ^ 8'h3c, p[7:0]};
				s++;
				p++;
			end
			chk(program_counter_out, pce);
			rdchk(rcr_pkg::OFS_SSP, {16'h0, s});
			rdchk(rcr_pkg::OFS_SP, {16'h0, p});
		end
	endtask : t_conditional_subroutine_exit
	// upper guard bits count only in wide or legacy mode
	task automatic t_legacy();
		int lat;
		logic [15:0] st [3] = '{16'h0000, 16'h0020, 16'h0400};
		for (int i = 0; i < 3; i++) begin
			wr(rcr_pkg::OFS_ST1, {16'h0, st[i]});
			flags_in <= '{40'h01_0000_0000, 1'b0, 1'b0, 1'b0, 1'b0};
			run(rcr_pkg::RCR_KIND_CONDITIONAL_SUBROUTINE_EXIT, rcr_pkg::COND_ACC_EQ0, lat);
			chk(taken_out, i == 0);
		end
	endtask : t_legacy
	task automatic t_reject();
		for (int k = 1; k < 4; k++) begin
			@(posedge clk_in);
			cmd_in <= '{1'b1, rcr_pkg::rcr_kind_t'(k), 4'h0, 1'b1};
			@(posedge clk_in);
			cmd_in <= '0;
			#1;
			chk(reject_out, 1'b1);
			chk(busy_out, 1'b0);
			chk(cmd_ready_out, 1'b1);
		end
	endtask : t_reject
	// reset, then the scenarios in turn
	initial begin
		rst_n_in = 1'b0;
		cmd_in = '0;
		flags_in = '0;
		wt = 2'h0;
		wb_cyc_in = 1'b0;
		wb_stb_in = 1'b0;
		wb_we_in = 1'b0;
		wb_adr_in = 8'h00;
		wb_sel_in = 4'h0;
		wb_dat_in = 32'h0;
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_regs();
		t_ret_slow(2'h0);
		t_ret_slow(2'h2);
		t_fast();
		t_interrupt_exit_slow();
		t_conditional_subroutine_exit();
		t_legacy();
		t_reject();
		test_done();
	end
endmodule : rcr_core_tb

// file: test/rcr_mem_model.sv
// rcr_mem_model: one read port of the data memory stacks.
// assumes the core holds rd and addr until ack; a word reads as {addr^key, addr} in the low bytes.
`timescale 1ns/1ps
module rcr_mem_model #(
	parameter logic [7:0] KEY = 8'h00
) (
	// clock
	input wire logic clk_in,
	// request and wait cycles before ack
	input rcr_pkg::rcr_mem_req_t req_in,
	input wire logic [1:0] wait_in,
	// answer
	output logic [15:0] rdata_out,
	output logic ack_out
);
	logic [1:0] cnt_q;
	logic [15:0] last_q;
	// ack after the set wait, in the same cycle when zero
	assign ack_out = req_in.rd && (cnt_q == wait_in);
	// outside an ack the bus toggles, so stale data never looks valid
	assign rdata_out = ack_out ? {req_in.addr[7:0] ^ KEY, req_in.addr[7:0]} : ~last_q;
	// wait counter and last bus value
	always_ff @(posedge clk_in) begin
		cnt_q <= (req_in.rd && !ack_out) ? cnt_q + 2'h1 : 2'h0;
		last_q <= rdata_out;
	end
endmodule : rcr_mem_model
